// [rtl/fhc_pkg.sv]
package fhc_pkg;

  // Clock rate
  localparam int CLK_MHZ = 200;

  // Pin timing, in the units printed
  localparam int T_AS_NS   = 10;
  localparam int T_WP_NS   = 200;
  localparam int T_WPH_NS  = 200;
  localparam int T_DH_NS   = 10;
  localparam int T_ACC_NS  = 350;
  localparam int T_OEHP_NS = 150;
  localparam int T_BLC_US  = 150;
  localparam int T_WC_MS   = 20;

  // Least times round up to whole cycles
  localparam int AS_CYC   = (T_AS_NS * CLK_MHZ + 999) / 1000;
  localparam int WP_CYC   = (T_WP_NS * CLK_MHZ + 999) / 1000;
  localparam int WPH_CYC  = (T_WPH_NS * CLK_MHZ + 999) / 1000;
  localparam int DH_CYC   = (T_DH_NS * CLK_MHZ + 999) / 1000;
  localparam int ACC_CYC  = (T_ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int OEHP_CYC = (T_OEHP_NS * CLK_MHZ + 999) / 1000;

  // Longest times round down
  localparam int BLC_CYC = T_BLC_US * CLK_MHZ;
  localparam int WC_CYC  = T_WC_MS * CLK_MHZ * 1000;

  // Safety margin before the byte-load window closes
  localparam int BLC_MARGIN_CYC = 100;

  // Extra read wait to cover the data synchroniser
  localparam int SYNC_CYC = 2;

  // Array geometry
  localparam int ADDR_W       = 18;
  localparam int DATA_W       = 8;
  localparam int SECTOR_LSB   = 8;
  localparam int SECTOR_BYTES = 256;
  localparam int TOGGLE_BIT   = 6;

  // Software code sequence
  localparam logic [17:0] CODE_ADDR_A  = 18'h05555;
  localparam logic [17:0] CODE_ADDR_B  = 18'h02AAA;
  localparam logic [7:0]  CODE_DATA_A  = 8'hAA;
  localparam logic [7:0]  CODE_DATA_B  = 8'h55;
  localparam logic [7:0]  CMD_PROG     = 8'hA0;
  localparam logic [7:0]  CMD_ID_ENTER = 8'h90;
  localparam logic [7:0]  CMD_ID_EXIT  = 8'hF0;
  localparam logic [1:0]  CODE_LAST    = 2'h2;

  // Host operations
  typedef enum logic [1:0] {
    FHC_OP_READ     = 2'h0,
    FHC_OP_PROG     = 2'h1,
    FHC_OP_ID_ENTER = 2'h2,
    FHC_OP_ID_EXIT  = 2'h3
  } fhc_op_t;

endpackage : fhc_pkg

// [rtl/fhc_bus_cyc.sv]
`timescale 1ns/1ps
`default_nettype none

module fhc_bus_cyc (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Cycle request
  input  wire logic        start_i,
  input  wire logic        wr_i,
  input  wire logic [17:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  output logic             done_o,
  output logic [7:0]       rdata_o,
  // Flash pins
  output logic             ce_n_o,
  output logic             oe_n_o,
  output logic             we_n_o,
  output logic [17:0]      addr_o,
  output logic [7:0]       dq_o,
  output logic             dq_oe_o,
  input  wire logic [7:0]  dq_i
);

  typedef enum logic [2:0] {E_IDLE, E_SETUP, E_WLOW, E_WHOLD, E_WHIGH, E_RACC, E_RHIGH}
    fhc_cyc_state_t;

  fhc_cyc_state_t state_q, state_d;
  logic [7:0]     cnt_q, cnt_d;
  logic           done_q, done_d;
  logic [7:0]     rdata_q, rdata_d;
  logic           ce_n_q, ce_n_d, oe_n_q, oe_n_d, we_n_q, we_n_d, dq_oe_q, dq_oe_d;
  logic [17:0]    addr_q, addr_d;
  logic [7:0]     dq_q, dq_d;
  logic [7:0]     sync1_q, sync2_q;

  // Data pins pass two flops before use
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
    end
    else
    begin
      sync1_q <= dq_i;
      sync2_q <= sync1_q;
    end
  end

  // Pin sequencing for one write or one read
  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    done_d  = 1'b0;
    rdata_d = rdata_q;
    ce_n_d  = ce_n_q;
    oe_n_d  = oe_n_q;
    we_n_d  = we_n_q;
    dq_oe_d = dq_oe_q;
    addr_d  = addr_q;
    dq_d    = dq_q;
    if (cnt_q != 8'h00)
    begin
      cnt_d = cnt_q - 8'h01;
    end
    case (state_q)
      E_IDLE:
      begin
        if (start_i)
        begin
          addr_d = addr_i;
          ce_n_d = 1'b0;
          if (wr_i)
          begin
            oe_n_d  = 1'b1;
            dq_d    = wdata_i;
            dq_oe_d = 1'b1;
            cnt_d   = 8'(fhc_pkg::AS_CYC - 1);
            state_d = E_SETUP;
          end
          else
          begin
            oe_n_d  = 1'b0;               // Both strobes cycle per read
            cnt_d   = 8'(fhc_pkg::ACC_CYC + fhc_pkg::SYNC_CYC - 1);
            state_d = E_RACC;
          end
        end
      end
      E_SETUP:
      begin
        if (cnt_q == 8'h00)
        begin
          we_n_d  = 1'b0;                 // OE already high here
          cnt_d   = 8'(fhc_pkg::WP_CYC - 1);
          state_d = E_WLOW;
        end
      end
      E_WLOW:
      begin
        if (cnt_q == 8'h00)
        begin
          we_n_d  = 1'b1;
          cnt_d   = 8'(fhc_pkg::DH_CYC - 1);
          state_d = E_WHOLD;
        end
      end
      E_WHOLD:
      begin
        if (cnt_q == 8'h00)
        begin
          ce_n_d  = 1'b1;
          dq_oe_d = 1'b0;
          cnt_d   = 8'(fhc_pkg::WPH_CYC - 1);
          state_d = E_WHIGH;
        end
      end
      E_WHIGH:
      begin
        if (cnt_q == 8'h00)
        begin
          done_d  = 1'b1;
          state_d = E_IDLE;
        end
      end
      E_RACC:
      begin
        if (cnt_q == 8'h00)
        begin
          rdata_d = sync2_q;
          ce_n_d  = 1'b1;
          oe_n_d  = 1'b1;
          cnt_d   = 8'(fhc_pkg::OEHP_CYC - 1);
          state_d = E_RHIGH;
        end
      end
      E_RHIGH:
      begin
        if (cnt_q == 8'h00)
        begin
          done_d  = 1'b1;
          state_d = E_IDLE;
        end
      end
      default:
      begin
        state_d = E_IDLE;
      end
    endcase
  end

  // Cycle state registers
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= E_IDLE;
      cnt_q   <= 8'h00;
      done_q  <= 1'b0;
      rdata_q <= 8'h00;
      ce_n_q  <= 1'b1;
      oe_n_q  <= 1'b1;
      we_n_q  <= 1'b1;
      dq_oe_q <= 1'b0;
      addr_q  <= 18'h00000;
      dq_q    <= 8'h00;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      done_q  <= done_d;
      rdata_q <= rdata_d;
      ce_n_q  <= ce_n_d;
      oe_n_q  <= oe_n_d;
      we_n_q  <= we_n_d;
      dq_oe_q <= dq_oe_d;
      addr_q  <= addr_d;
      dq_q    <= dq_d;
    end
  end

  assign done_o  = done_q;
  assign rdata_o = rdata_q;
  assign ce_n_o  = ce_n_q;
  assign oe_n_o  = oe_n_q;
  assign we_n_o  = we_n_q;
  assign addr_o  = addr_q;
  assign dq_o    = dq_q;
  assign dq_oe_o = dq_oe_q;

endmodule : fhc_bus_cyc

`default_nettype wire

// [rtl/fhc_flash_host.sv]
`timescale 1ns/1ps
`default_nettype none

module fhc_flash_host #(
  parameter int BLC_CYC = fhc_pkg::BLC_CYC,
  parameter int WC_CYC  = fhc_pkg::WC_CYC
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Command port
  input  wire logic        cmd_valid_i,
  output logic             cmd_ready_o,
  input  wire logic [1:0]  cmd_op_i,
  input  wire logic [17:0] cmd_addr_i,
  // Sector data stream
  input  wire logic        wr_valid_i,
  output logic             wr_ready_o,
  input  wire logic [7:0]  wr_data_i,
  // Response
  output logic             rsp_valid_o,
  output logic [7:0]       rsp_data_o,
  output logic             rsp_err_o,
  // Flash pins
  output logic             ce_n_o,
  output logic             oe_n_o,
  output logic             we_n_o,
  output logic [17:0]      addr_o,
  output logic [7:0]       dq_o,
  output logic             dq_oe_o,
  input  wire logic [7:0]  dq_i
);

  localparam int GW = $clog2(BLC_CYC + 1);
  localparam int TW = $clog2(WC_CYC + 1);
  localparam logic [GW-1:0] GAP_LIM = GW'(BLC_CYC - fhc_pkg::BLC_MARGIN_CYC);
  localparam logic [TW-1:0] WC_LIM  = TW'(WC_CYC);
  localparam logic [GW-1:0] BLC_LIM = GW'(BLC_CYC);

  typedef enum logic [2:0] {S_IDLE, S_READ, S_CODE, S_LOAD_WAIT, S_LOAD_CYC, S_SETTLE, S_POLL}
    fhc_state_t;

  fhc_state_t        state_q, state_d;
  fhc_pkg::fhc_op_t  op_q, op_d;
  logic [17:0]       addr_q, addr_d;
  logic [1:0]        step_q, step_d;
  logic [7:0]        idx_q, idx_d;
  logic [GW-1:0]     gap_q, gap_d;
  logic [TW-1:0]     wc_q, wc_d;
  logic              first_q, first_d;
  logic              prev_q, prev_d;
  logic              cmd_rdy_q, cmd_rdy_d;
  logic              wr_rdy_q, wr_rdy_d;
  logic              rsp_v_q, rsp_v_d;
  logic [7:0]        rsp_d_q, rsp_d_d;
  logic              rsp_e_q, rsp_e_d;
  logic              start_q, start_d;
  logic              cwr_q, cwr_d;
  logic [17:0]       caddr_q, caddr_d;
  logic [7:0]        cdata_q, cdata_d;
  logic              cyc_done;
  logic [7:0]        cyc_rdata;
  logic [17:0]       code_addr;
  logic [7:0]        code_data;
  logic [17:0]       poll_addr;

  // Pin-level cycle engine
  fhc_bus_cyc u_cyc (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .start_i (start_q),
    .wr_i    (cwr_q),
    .addr_i  (caddr_q),
    .wdata_i (cdata_q),
    .done_o  (cyc_done),
    .rdata_o (cyc_rdata),
    .ce_n_o  (ce_n_o),
    .oe_n_o  (oe_n_o),
    .we_n_o  (we_n_o),
    .addr_o  (addr_o),
    .dq_o    (dq_o),
    .dq_oe_o (dq_oe_o),
    .dq_i    (dq_i)
  );

  // Code write for the given step: two unlock writes then the command
  always_comb
  begin
    code_addr = (step_d == 2'h1) ? fhc_pkg::CODE_ADDR_B : fhc_pkg::CODE_ADDR_A;
    code_data = fhc_pkg::CODE_DATA_A;
    if (step_d == 2'h1)
    begin
      code_data = fhc_pkg::CODE_DATA_B;
    end
    else if (step_d == fhc_pkg::CODE_LAST)
    begin
      case (op_d)
        fhc_pkg::FHC_OP_PROG:     code_data = fhc_pkg::CMD_PROG;
        fhc_pkg::FHC_OP_ID_ENTER: code_data = fhc_pkg::CMD_ID_ENTER;
        default:                  code_data = fhc_pkg::CMD_ID_EXIT;
      endcase
    end
  end

  // Polls use the last loaded byte of the sector, never changing
  assign poll_addr = {addr_q[17:fhc_pkg::SECTOR_LSB], 8'hFF};

  // Command sequencer
  always_comb
  begin
    state_d   = state_q;
    op_d      = op_q;
    addr_d    = addr_q;
    step_d    = step_q;
    idx_d     = idx_q;
    gap_d     = gap_q;
    wc_d      = wc_q;
    first_d   = first_q;
    prev_d    = prev_q;
    cmd_rdy_d = cmd_rdy_q;
    wr_rdy_d  = wr_rdy_q;
    rsp_v_d   = 1'b0;
    rsp_d_d   = rsp_d_q;
    rsp_e_d   = rsp_e_q;
    start_d   = 1'b0;
    cwr_d     = cwr_q;
    caddr_d   = caddr_q;
    cdata_d   = cdata_q;
    case (state_q)
      S_IDLE:
      begin
        if (cmd_valid_i && cmd_rdy_q)
        begin
          op_d      = fhc_pkg::fhc_op_t'(cmd_op_i);
          addr_d    = cmd_addr_i;
          step_d    = 2'h0;
          cmd_rdy_d = 1'b0;
          rsp_e_d   = 1'b0;
          start_d   = 1'b1;
          if (fhc_pkg::fhc_op_t'(cmd_op_i) == fhc_pkg::FHC_OP_READ)
          begin
            cwr_d   = 1'b0;
            caddr_d = cmd_addr_i;
            state_d = S_READ;
          end
          else
          begin
            cwr_d   = 1'b1;
            caddr_d = code_addr;
            cdata_d = code_data;
            state_d = S_CODE;
          end
        end
      end
      S_READ:
      begin
        if (cyc_done)
        begin
          rsp_d_d   = cyc_rdata;
          rsp_v_d   = 1'b1;
          cmd_rdy_d = 1'b1;
          state_d   = S_IDLE;
        end
      end
      S_CODE:
      begin
        if (cyc_done)
        begin
          if (step_q != fhc_pkg::CODE_LAST)
          begin
            step_d  = step_q + 2'h1;
            start_d = 1'b1;
            caddr_d = code_addr;
            cdata_d = code_data;
          end
          else if (op_q == fhc_pkg::FHC_OP_PROG)
          begin
            idx_d    = 8'h00;
            gap_d    = '0;
            wr_rdy_d = 1'b1;
            state_d  = S_LOAD_WAIT;
          end
          else
          begin
            rsp_d_d   = 8'h00;
            rsp_v_d   = 1'b1;
            cmd_rdy_d = 1'b1;
            state_d   = S_IDLE;
          end
        end
      end
      S_LOAD_WAIT:
      begin
        gap_d = gap_q + GW'(1);
        if (wr_valid_i && wr_rdy_q)
        begin
          wr_rdy_d = 1'b0;
          start_d  = 1'b1;
          gap_d    = '0;
          caddr_d  = {addr_q[17:fhc_pkg::SECTOR_LSB], idx_q};
          cdata_d  = wr_data_i;
          state_d  = S_LOAD_CYC;
        end
        else if (gap_q >= GAP_LIM)
        begin
          // Source too slow: the sector would close short, so report it
          wr_rdy_d  = 1'b0;
          rsp_e_d   = 1'b1;
          rsp_v_d   = 1'b1;
          cmd_rdy_d = 1'b1;
          state_d   = S_IDLE;
        end
      end
      S_LOAD_CYC:
      begin
        gap_d = gap_q + GW'(1);
        if (cyc_done)
        begin
          if (idx_q == 8'(fhc_pkg::SECTOR_BYTES - 1))
          begin
            cwr_d   = 1'b0;
            caddr_d = poll_addr;
            gap_d   = '0;
            first_d = 1'b1;
            wc_d    = '0;
            state_d = S_SETTLE;
          end
          else
          begin
            idx_d    = idx_q + 8'h01;
            wr_rdy_d = 1'b1;
            state_d  = S_LOAD_WAIT;
          end
        end
      end
      S_SETTLE:
      begin
        // Polls before the load window closes would see stable data and end early
        gap_d = gap_q + GW'(1);
        if (gap_q == BLC_LIM)
        begin
          start_d = 1'b1;
          state_d = S_POLL;
        end
      end
      S_POLL:
      begin
        if (wc_q != WC_LIM)
        begin
          wc_d = wc_q + TW'(1);
        end
        if (cyc_done)
        begin
          prev_d  = cyc_rdata[fhc_pkg::TOGGLE_BIT];
          first_d = 1'b0;
          // Finished when the toggle bit of two successive reads agrees, or with an error once wc_q reaches WC_LIM
          if (!first_q && (cyc_rdata[fhc_pkg::TOGGLE_BIT] == prev_q))
          begin
            rsp_d_d   = cyc_rdata;
            rsp_v_d   = 1'b1;
            cmd_rdy_d = 1'b1;
            state_d   = S_IDLE;
          end
          else if (wc_q == WC_LIM)
          begin
            rsp_d_d   = cyc_rdata;
            rsp_e_d   = 1'b1;
            rsp_v_d   = 1'b1;
            cmd_rdy_d = 1'b1;
            state_d   = S_IDLE;
          end
          else
          begin
            start_d = 1'b1;
          end
        end
      end
      default:
      begin
        cmd_rdy_d = 1'b1;
        state_d   = S_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_q   <= S_IDLE;
      op_q      <= fhc_pkg::FHC_OP_READ;
      addr_q    <= 18'h00000;
      step_q    <= 2'h0;
      idx_q     <= 8'h00;
      gap_q     <= '0;
      wc_q      <= '0;
      first_q   <= 1'b0;
      prev_q    <= 1'b0;
      cmd_rdy_q <= 1'b1;
      wr_rdy_q  <= 1'b0;
      rsp_v_q   <= 1'b0;
      rsp_d_q   <= 8'h00;
      rsp_e_q   <= 1'b0;
      start_q   <= 1'b0;
      cwr_q     <= 1'b0;
      caddr_q   <= 18'h00000;
      cdata_q   <= 8'h00;
    end
    else
    begin
      state_q   <= state_d;
      op_q      <= op_d;
      addr_q    <= addr_d;
      step_q    <= step_d;
      idx_q     <= idx_d;
      gap_q     <= gap_d;
      wc_q      <= wc_d;
      first_q   <= first_d;
      prev_q    <= prev_d;
      cmd_rdy_q <= cmd_rdy_d;
      wr_rdy_q  <= wr_rdy_d;
      rsp_v_q   <= rsp_v_d;
      rsp_d_q   <= rsp_d_d;
      rsp_e_q   <= rsp_e_d;
      start_q   <= start_d;
      cwr_q     <= cwr_d;
      caddr_q   <= caddr_d;
      cdata_q   <= cdata_d;
    end
  end

  assign cmd_ready_o = cmd_rdy_q;
  assign wr_ready_o  = wr_rdy_q;
  assign rsp_valid_o = rsp_v_q;
  assign rsp_data_o  = rsp_d_q;
  assign rsp_err_o   = rsp_e_q;

endmodule : fhc_flash_host

`default_nettype wire

// [verification/fhc_flash_host_asserts.sv]
`timescale 1ns/1ps
`default_nettype none

module fhc_flash_host_asserts #(
  parameter int BLC_CYC = 400
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Command and response
  input  wire logic        cmd_valid_i,
  input  wire logic        cmd_ready_o,
  input  wire logic [1:0]  cmd_op_i,
  input  wire logic [17:0] cmd_addr_i,
  input  wire logic        rsp_valid_o,
  input  wire logic        rsp_err_o,
  // Flash pins
  input  wire logic        ce_n_o,
  input  wire logic        oe_n_o,
  input  wire logic        we_n_o,
  input  wire logic [17:0] addr_o,
  input  wire logic [7:0]  dq_o,
  input  wire logic        dq_oe_o
);
  logic       load_q, load_d, we_q, fell, rose;
  logic [9:0] sect_q, sect_d;
  logic [8:0] cnt_q, cnt_d;
  int         gap_q, gap_d, low_q, low_d;

  // Write strobe edges
  assign fell = we_q && !we_n_o;
  assign rose = !we_q && we_n_o;

  // Sector load phase, byte count, gap and pulse width
  always_comb
  begin
    load_d = load_q;
    sect_d = sect_q;
    cnt_d  = cnt_q;
    gap_d  = gap_q + 32'h1;
    low_d  = we_n_o ? 32'h0 : low_q + 32'h1;
    if (cmd_valid_i && cmd_ready_o && cmd_op_i == fhc_pkg::FHC_OP_PROG)
      sect_d = cmd_addr_i[17:8];
    if (fell && load_q)
    begin
      cnt_d = cnt_q + 9'h1;
      gap_d = 32'h0;
    end
    if (rose && addr_o == fhc_pkg::CODE_ADDR_A && dq_o == fhc_pkg::CMD_PROG)
    begin
      load_d = 1'b1;
      cnt_d  = 9'h0;
      gap_d  = 32'h0;
    end
    if (rsp_valid_o)
      load_d = 1'b0;
  end

  // Tracking registers
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      load_q <= 1'b0;
      we_q   <= 1'b1;
      sect_q <= 10'h0;
      cnt_q  <= 9'h0;
      gap_q  <= 32'h0;
      low_q  <= 32'h0;
    end
    else
    begin
      load_q <= load_d;
      we_q   <= we_n_o;
      sect_q <= sect_d;
      cnt_q  <= cnt_d;
      gap_q  <= gap_d;
      low_q  <= low_d;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  oe_guard_a:
    assert property (!ce_n_o && !we_n_o |-> oe_n_o) else $error("Output enable low in write");
  no_fight_a:
    assert property (!oe_n_o |-> !dq_oe_o) else $error("Host drives data during read");
  wdata_hold_a:
    assert property (!we_n_o |-> dq_oe_o && $stable(dq_o)) else $error("Write data moved");
  wp_width_a:
    assert property (rose |-> low_q >= fhc_pkg::WP_CYC) else $error("Write pulse too short");
  sector_addr_a:
    assert property (load_q && fell |-> addr_o[17:8] == sect_q) else $error("Sector addr wrong");
  byte_count_a:
    assert property (load_q && rsp_valid_o && !rsp_err_o |-> cnt_q == 9'h100)
      else $error("Sector not fully loaded");
  no_extra_a:
    assert property (load_q |-> cnt_q <= 9'h100) else $error("Too many byte loads");
  load_gap_a:
    assert property (load_q && cnt_q < 9'h100 |-> gap_q < BLC_CYC) else $error("Byte gap too long");
  poll_addr_a:
    assert property (load_q && cnt_q == 9'h100 && !oe_n_o |-> addr_o == {sect_q, 8'hFF})
      else $error("Poll address moved");
  rsp_ready_a:
    assert property (rsp_valid_o |-> cmd_ready_o ##1 !rsp_valid_o) else $error("Response not idle");

  // Main scenarios
  prog_done_c: cover property (load_q && rsp_valid_o && !rsp_err_o);
  prog_abort_c: cover property (rsp_valid_o && rsp_err_o);
  poll_read_c: cover property (load_q && cnt_q == 9'h100 && $fell(oe_n_o));

endmodule : fhc_flash_host_asserts

`default_nettype wire

// [verification/fhc_flash_model.sv]
`timescale 1ns/1ps
`default_nettype none

module fhc_flash_model #(
  parameter int         BLC_LIM    = 400,
  parameter int         WC_LIM     = 600,
  parameter logic [7:0] MAKER_CODE = 8'h3C,  // Arbitrary value
  parameter logic [7:0] PART_CODE  = 8'hC3   // Arbitrary value
) (
  // Timer clock
  input  wire logic        clk_i,
  // Memory pins
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic [17:0] addr_i,
  input  wire logic [7:0]  dq_i,
  output logic [7:0]       dq_o,
  // Reads seen while busy
  output logic [15:0]      polls_o
);
  logic [7:0]   mem [int];
  logic [7:0]   latch [256];
  logic [255:0] got;
  logic [1:0]   seq;
  logic [9:0]   sect;
  logic [7:0]   last_d, hold;
  logic         id_mode, loading, busy, tog, rd_en;
  int           gap, wc;

  function automatic logic [7:0] rd(input logic [17:0] a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction : rd

  // Power-up state
  initial
  begin
    id_mode = 1'b0;
    tog     = 1'b1;  // Start level is arbitrary
    {loading, busy, seq, got, gap, wc, hold, last_d, polls_o} = '0;
  end

  // Code decode and byte capture on write strobe release
  always @(posedge we_n_i)
  begin
    if (!ce_n_i && oe_n_i)
    begin
      if (loading)
      begin
        if (got == '0)
          sect = addr_i[17:8];
        latch[addr_i[7:0]] = dq_i;
        got[addr_i[7:0]]   = 1'b1;
        last_d             = dq_i;
        gap                = 0;
      end
      else if (seq == 2'h0 && addr_i == fhc_pkg::CODE_ADDR_A && dq_i == fhc_pkg::CODE_DATA_A)
        seq = 2'h1;
      else if (seq == 2'h1 && addr_i == fhc_pkg::CODE_ADDR_B && dq_i == fhc_pkg::CODE_DATA_B)
        seq = 2'h2;
      else if (seq == 2'h2 && addr_i == fhc_pkg::CODE_ADDR_A)
      begin
        seq     = 2'h0;
        loading = (dq_i == fhc_pkg::CMD_PROG);
        got     = '0;
        gap     = 0;
        if (dq_i == fhc_pkg::CMD_ID_ENTER)
          id_mode = 1'b1;
        if (dq_i == fhc_pkg::CMD_ID_EXIT)
          id_mode = 1'b0;
      end
      else
        seq = 2'h0;
    end
  end

  // Load window closes, then the program timer runs
  always @(posedge clk_i)
  begin
    gap = gap + 1;
    wc  = wc + 1;
    if (loading && gap >= BLC_LIM)
    begin
      loading = 1'b0;
      busy    = 1'b1;
      wc      = 0;
    end
    if (busy && wc >= WC_LIM)
    begin
      for (int i = 0; i < 256; i++)
        mem[{sect, i[7:0]}] = got[i] ? latch[i] : 8'h00;  // Unloaded bytes spoiled
      busy = 1'b0;  // Toggling stops
    end
  end

  assign rd_en = !ce_n_i && !oe_n_i && we_n_i;

  // Each read start while busy, by either strobe, advances the toggle bit
  always @(posedge rd_en)
  begin
    if (busy)
    begin
      tog     = ~tog;
      polls_o = polls_o + 16'h1;
    end
  end

  // Read data; released bus shows the inverse of the last value
  always @*
  begin
    if (!rd_en)
      dq_o = ~hold;
    else
    begin
      if (busy)
        dq_o = {~last_d[7], tog, last_d[5:0]};
      else if (id_mode && addr_i[17:1] == 17'h0)
        dq_o = addr_i[0] ? PART_CODE : MAKER_CODE;
      else
        dq_o = rd(addr_i);
      hold = dq_o;
    end
  end

endmodule : fhc_flash_model

`default_nettype wire

// [verification/fhc_flash_host_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module fhc_flash_host_tb;
  logic        clk, rst_n, cmd_valid, cmd_ready, wr_valid, wr_ready, rsp_valid, rsp_err;
  logic        ce_n, oe_n, we_n, dq_oe;
  logic [1:0]  cmd_op;
  logic [17:0] cmd_addr, addr;
  logic [7:0]  wr_data, rsp_data, dq_h, dq_f, dq_w, d;
  logic [15:0] polls;
  logic        e;
  int          error_cnt, num_checks;

  // Shared data line
  assign dq_w = dq_oe ? dq_h : dq_f;

  fhc_flash_host #(.BLC_CYC(400), .WC_CYC(2000)) u_dut (
    .clk_i(clk), .rst_n_i(rst_n), .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready),
    .cmd_op_i(cmd_op), .cmd_addr_i(cmd_addr), .wr_valid_i(wr_valid), .wr_ready_o(wr_ready),
    .wr_data_i(wr_data), .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .rsp_err_o(rsp_err),
    .ce_n_o(ce_n), .oe_n_o(oe_n), .we_n_o(we_n), .addr_o(addr), .dq_o(dq_h),
    .dq_oe_o(dq_oe), .dq_i(dq_w));

  fhc_flash_model #(.BLC_LIM(400), .WC_LIM(600)) u_mem (
    .clk_i(clk), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .addr_i(addr),
    .dq_i(dq_w), .dq_o(dq_f), .polls_o(polls));

  // Clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // One command, its sector bytes, and the response
  task automatic run_cmd(input logic [1:0] op, input logic [17:0] a, input int nb);
    int n;
    for (n = 0; cmd_ready !== 1'b1 && n < 1000; n++)
      @(negedge clk);
    cmd_valid = 1'b1;
    cmd_op    = op;
    cmd_addr  = a;
    @(negedge clk);
    cmd_valid = 1'b0;
    for (int i = 0; i < nb; i++)
    begin
      for (n = 0; wr_ready !== 1'b1 && n < 1000; n++)
        @(negedge clk);
      wr_valid = 1'b1;
      wr_data  = 8'(i) ^ 8'h5A;
      @(negedge clk);
      wr_valid = 1'b0;
    end
    for (n = 0; rsp_valid !== 1'b1 && n < 5000; n++)
      @(negedge clk);
    check("rsp_valid", 8'h01, {7'h0, rsp_valid});
    d = rsp_data;
    e = rsp_err;
  endtask : run_cmd

  task automatic t_reset;
    check("idle strobes", 8'h0F, {4'h0, ce_n, oe_n, we_n, cmd_ready});
    check("idle drives", 8'h00, {6'h0, dq_oe, wr_ready});
  endtask : t_reset

  task automatic t_ident;
    run_cmd(fhc_pkg::FHC_OP_ID_ENTER, 18'h0, 0);
    run_cmd(fhc_pkg::FHC_OP_READ, 18'h00000, 0);
    check("maker code", 8'h3C, d);
    run_cmd(fhc_pkg::FHC_OP_READ, 18'h00001, 0);
    check("part code", 8'hC3, d);
    run_cmd(fhc_pkg::FHC_OP_READ, 18'h00100, 0);
    check("id upper addr", 8'hFF, d);
    run_cmd(fhc_pkg::FHC_OP_ID_EXIT, 18'h0, 0);
    run_cmd(fhc_pkg::FHC_OP_READ, 18'h00000, 0);
    check("normal read", 8'hFF, d);
  endtask : t_ident

  task automatic t_program;
    run_cmd(fhc_pkg::FHC_OP_PROG, 18'h00342, 256);
    check("prog err", 8'h00, {7'h0, e});
    check("final poll", 8'hA5, d);
    check("busy polls", 8'h01, {7'h0, polls >= 16'h2});
    run_cmd(fhc_pkg::FHC_OP_READ, 18'h00300, 0);
    check("byte 00", 8'h5A, d);
    run_cmd(fhc_pkg::FHC_OP_READ, 18'h00380, 0);
    check("byte 80", 8'hDA, d);
  endtask : t_program

  task automatic t_abort;
    run_cmd(fhc_pkg::FHC_OP_PROG, 18'h00500, 4);
    check("abort err", 8'h01, {7'h0, e});
    check("abort ready", 8'h00, {7'h0, wr_ready});
  endtask : t_abort

  task automatic summarize;
    $display("Checks %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize

  // Main sequence
  initial
  begin
    {rst_n, cmd_valid, wr_valid, cmd_op, cmd_addr, wr_data} = '0;
    error_cnt  = 0;
    num_checks = 0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    t_reset();
    t_ident();
    t_program();
    t_abort();
    summarize();
  end

  // Watchdog, about three times the expected run
  initial
  begin
    #400_000;
    error_cnt++;
    summarize();
  end

endmodule : fhc_flash_host_tb

bind fhc_flash_host fhc_flash_host_asserts #(.BLC_CYC(BLC_CYC)) u_chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
  .cmd_op_i(cmd_op_i), .cmd_addr_i(cmd_addr_i), .rsp_valid_o(rsp_valid_o),
  .rsp_err_o(rsp_err_o), .ce_n_o(ce_n_o), .oe_n_o(oe_n_o), .we_n_o(we_n_o),
  .addr_o(addr_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o));

`default_nettype wire
